// ---- core/pmc_bclk_div.sv ----
`timescale 1ns/1ps
module pmc_bclk_div
    import pmc_pkg::*;
#(
    parameter int CW = 4
)(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          run,
    input  wire logic [2:0]    shift,
    output logic               tick_r
);
    logic [CW-1:0] cnt_r;
    logic [CW:0]   span;
    logic [CW-1:0] limit;

    if (CW < 4)
    begin : g_chk
        $error("pmc_bclk_div: CW must cover divide by 16");
    end

    // shift beyond the widest ratio is clamped to divide by 16
    always_comb
    begin
        span  = (CW+1)'(1) << ((shift > SH_DIV16) ? SH_DIV16 : shift);
        limit = CW'(span - (CW+1)'(1));
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end
        else if (!run)
        begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end
        else if (cnt_r >= limit)
        begin
            cnt_r  <= '0;
            tick_r <= 1'b1;
        end
        else
        begin
            cnt_r  <= cnt_r + CW'(1);
            tick_r <= 1'b0;
        end
    end
endmodule // pmc_bclk_div

// ---- core/pmc_ctrl.sv ----
// Summary of operation
// - high speed: bus clock is main divided 1
// - medium speed: main divided 2, 4, 8, 16
// - low speed: sub clock drives bus, main runs
// - low power: main stopped, sub peripherals only
// - wait: cpu halted, oscillators keep running
// - stop: oscillators, cpu, peripherals all stopped
// - reset or enabled interrupt ends stop mode
// - reset and main-clock stop set divide bit
// - wait wake restores previous bus clock immediately
// - stop from main clock restarts divided by 8
// - stop from sub clock keeps all select bits
// - adc wakes wait only, one-shot, peripherals on
// - serial wakes stop, and wait with peripherals off, only with external clock
// - timer wakes stop in event mode only
// - usb stop wake: resume in suspend, vbus
// - stop interrupt clears stop bit, restarts oscillators
// - entry fetches info, then clears request bit
// - save flags, clear, push flags, pc, ipl
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module pmc_ctrl
    import pmc_pkg::*;
#(
    parameter int OSC_N = OSC_STAB_CYC
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        wait_req,
    input  wire logic        sub_osc_in,
    input  wire logic        irq_key,
    input  wire logic        irq_adc,
    input  wire logic        irq_serial,
    input  wire logic        irq_timer,
    input  wire logic        irq_usb_resume,
    input  wire logic        irq_usb_vbus,
    input  wire logic        irq_usb_other,
    input  wire logic        irq_ext,
    input  wire logic        irq_nmi,
    input  wire logic        adc_one_shot,
    input  wire logic        serial_ext_clk,
    input  wire logic        timer_event_cnt,
    input  wire logic        timer_src_subclock_div32,
    input  wire logic        usb_suspended,
    input  wire logic [5:0]  int_info_num,
    input  wire logic [2:0]  int_info_lvl,
    output logic             bclk_tick,
    output logic             cpu_run_r,
    output logic             main_osc_en_r,
    output logic             sub_osc_en_r,
    output logic             periph_clk_en_r,
    output logic             subclk_periph_en_r,
    output logic             info_rd_r,
    output logic [19:0]      info_addr,
    output logic             req_clr_r,
    output logic             flg_save_r,
    output logic             flg_clr_r,
    output logic             u_keep_r,
    output logic             push_flg_r,
    output logic             push_pc_r,
    output logic             ipl_load_r,
    output logic [2:0]       ipl_val_r
);
    localparam int OSC_MAX = OSC_N + 2;

    if (OSC_N < 1 || OSC_N > 998)
    begin : g_chk
        $error("pmc_ctrl: OSC_N out of range");
    end

    pmc_state_t  st_r, st_nxt;
    logic [7:0]  ctl0_r, ctl1_r;
    logic        wen_r;
    logic [9:0]  osc_cnt_r;
    logic [5:0]  num_r;
    logic [2:0]  lvl_r;
    logic [31:0] prdata_r;
    logic        sub_s1_r, sub_s2_r, sub_s3_r;
    logic        wr, rd_setup, map_hit;
    logic        wpcs, mosc, div0, syssel, acs, divlo, divhi;
    logic        wake_wait, wake_stop, sub_tick, div_tick;
    logic [2:0]  shift;

    assign wpcs   = ctl0_r[B0_WPCS];
    assign mosc   = ctl0_r[B0_MOSC];
    assign div0   = ctl0_r[B0_DIV0];
    assign syssel = ctl0_r[B0_SYSSEL];
    assign acs    = ctl1_r[B1_ACS];
    assign divlo  = ctl1_r[B1_DIVLO];
    assign divhi  = ctl1_r[B1_DIVHI];

    // apb slave: zero wait states, read data sampled in setup phase
    assign wr       = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign map_hit  = (paddr == OFS_CLKCTL0) || (paddr == OFS_CLKCTL1)
                   || (paddr == OFS_PROTECT) || (paddr == OFS_STATUS);
    assign pready   = psel && penable;
    assign pslverr  = psel && penable && !map_hit;
    assign prdata   = prdata_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= '0;
        else if (rd_setup)
        begin
            case (paddr)
                OFS_CLKCTL0: prdata_r <= {24'h00_0000, ctl0_r};
                OFS_CLKCTL1: prdata_r <= {24'h00_0000, ctl1_r};
                OFS_PROTECT: prdata_r <= {31'h0000_0000, wen_r};
                OFS_STATUS:  prdata_r <= {22'h00_0000, lvl_r,
                                 st_r == s_stop, st_r == s_wait,
                                 sub_osc_en_r, main_osc_en_r,
                                 periph_clk_en_r, cpu_run_r, 1'b0};
                default:     prdata_r <= '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wen_r <= 1'b0;
        else if (wr && paddr == OFS_PROTECT)
            wen_r <= pwdata[BP_WEN];
    end

    // clock control 0; the stop-entry divide bit wins over a write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctl0_r <= CLKCTL0_RST;
        else if (st_r == s_run && acs && !syssel)
            ctl0_r[B0_DIV0] <= 1'b1;
        else if (wr && wen_r && paddr == OFS_CLKCTL0)
            ctl0_r <= pwdata[7:0];
    end

    // clock control 1; the stop bit is cleared by a wake interrupt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctl1_r <= CLKCTL1_RST;
        else if (st_r == s_stop && wake_stop)
            ctl1_r[B1_ACS] <= 1'b0;
        else if (wr && wen_r && paddr == OFS_CLKCTL1)
            ctl1_r <= pwdata[7:0];
    end

    // wake qualification per low-power mode
    always_comb
    begin
        wake_wait = irq_key || irq_ext || irq_nmi
                 || irq_usb_resume || irq_usb_vbus || irq_usb_other;
        if (!wpcs)
            wake_wait = wake_wait || irq_serial || irq_timer
                     || (irq_adc && adc_one_shot);
        else
            wake_wait = wake_wait
                     || (irq_serial && serial_ext_clk)
                     || (irq_timer && (timer_event_cnt
                         || timer_src_subclock_div32));
        wake_stop = irq_key || irq_ext || irq_nmi || irq_usb_vbus
                 || (irq_usb_resume && usb_suspended)
                 || (irq_serial && serial_ext_clk)
                 || (irq_timer && timer_event_cnt);
    end

    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            s_run:
                if (acs)
                    st_nxt = s_stop;
                else if (wait_req)
                    st_nxt = s_wait;
            s_wait:
                if (wake_wait)
                    st_nxt = s_fetch;
            s_stop:
                if (wake_stop)
                    st_nxt = s_osc;
            s_osc:
                if (osc_cnt_r == 10'(OSC_N))
                    st_nxt = s_fetch;
            s_fetch:  st_nxt = s_clr;
            s_clr:    st_nxt = s_save;
            s_save:   st_nxt = s_flags;
            s_flags:  st_nxt = s_pushf;
            s_pushf:  st_nxt = s_pushpc;
            s_pushpc: st_nxt = s_ipl;
            s_ipl:    st_nxt = s_run;
            default:  st_nxt = s_run;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_r <= s_run;
        else
            st_r <= st_nxt;
    end

    // oscillator start-up count; runs only after a stop wake
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            osc_cnt_r <= '0;
        else if (st_r == s_osc)
            osc_cnt_r <= osc_cnt_r + 10'h001;
        else
            osc_cnt_r <= '0;
    end

    // accepted interrupt captured from the information read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            num_r <= '0;
            lvl_r <= '0;
        end
        else if (st_r == s_fetch)
        begin
            num_r <= int_info_num;
            lvl_r <= int_info_lvl;
        end
    end

    // interrupt entry strobes, one cycle each, in fixed order
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            info_rd_r  <= 1'b0;
            req_clr_r  <= 1'b0;
            flg_save_r <= 1'b0;
            flg_clr_r  <= 1'b0;
            u_keep_r   <= 1'b0;
            push_flg_r <= 1'b0;
            push_pc_r  <= 1'b0;
            ipl_load_r <= 1'b0;
            ipl_val_r  <= '0;
        end
        else
        begin
            info_rd_r  <= st_nxt == s_fetch;
            req_clr_r  <= st_nxt == s_clr;
            flg_save_r <= st_nxt == s_save;
            flg_clr_r  <= st_nxt == s_flags;
            u_keep_r   <= st_nxt == s_flags && num_r >= SWI_LO
                       && num_r <= SWI_HI;
            push_flg_r <= st_nxt == s_pushf;
            push_pc_r  <= st_nxt == s_pushpc;
            ipl_load_r <= st_nxt == s_ipl;
            if (st_nxt == s_ipl)
                ipl_val_r <= lvl_r;
        end
    end

    assign info_addr = INT_INFO_ADDR;

    // clock gating outputs follow the state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu_run_r          <= 1'b1;
            main_osc_en_r      <= 1'b1;
            sub_osc_en_r       <= 1'b1;
            periph_clk_en_r    <= 1'b1;
            subclk_periph_en_r <= 1'b1;
        end
        else
        begin
            cpu_run_r <= st_nxt != s_wait && st_nxt != s_stop
                      && st_nxt != s_osc;
            main_osc_en_r <= st_nxt != s_stop
                          && !(syssel && mosc);
            sub_osc_en_r <= st_nxt != s_stop;
            periph_clk_en_r <= (st_nxt == s_run
                             || (st_nxt == s_wait && !wpcs)
                             || (st_nxt != s_stop && st_nxt != s_osc
                                 && st_nxt != s_wait))
                            && !(syssel && mosc);
            subclk_periph_en_r <= st_nxt != s_stop;
        end
    end

    // sub oscillator pin: two-stage synchroniser, then edge detect
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sub_s1_r <= 1'b0;
            sub_s2_r <= 1'b0;
            sub_s3_r <= 1'b0;
        end
        else
        begin
            sub_s1_r <= sub_osc_in;
            sub_s2_r <= sub_s1_r;
            sub_s3_r <= sub_s2_r;
        end
    end

    assign sub_tick = sub_s2_r && !sub_s3_r;

    always_comb
    begin
        if (div0)
            shift = SH_DIV8;
        else
        begin
            case ({divhi, divlo})
                2'b00:   shift = SH_DIV1;
                2'b01:   shift = SH_DIV2;
                2'b10:   shift = SH_DIV4;
                default: shift = SH_DIV16;
            endcase
        end
    end

    pmc_bclk_div #(
        .CW      (4)
    ) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (main_osc_en_r && !syssel),
        .shift   (shift),
        .tick_r  (div_tick)
    );

    // bus clock runs in wait too; wait wake needs no restart
    assign bclk_tick = (st_r != s_stop && st_r != s_osc)
                    && (syssel ? sub_tick : div_tick);

    a_stop_div8: assert property (@(posedge pclk)
        disable iff (!presetn)
        (st_r == s_run && acs && !syssel) |=> div0 && st_r == s_stop
        ) else $error("stop from main clock did not force div by 8");

    a_stop_keep_sub: assert property (@(posedge pclk)
        disable iff (!presetn)
        (st_r == s_run && acs && syssel && !wr) |=>
        $stable({div0, divlo, divhi, syssel})
        ) else $error("stop from sub clock changed select bits");

    a_stop_all_off: assert property (@(posedge pclk)
        disable iff (!presetn)
        (st_r == s_stop) [*2] |-> !main_osc_en_r && !sub_osc_en_r
        && !cpu_run_r && !periph_clk_en_r
        ) else $error("clock left running in stop");

    a_wait_osc_on: assert property (@(posedge pclk)
        disable iff (!presetn)
        (st_r == s_wait) [*2] |-> sub_osc_en_r && !cpu_run_r
        ) else $error("wait mode oscillator or cpu wrong");

    a_stop_wake_clr: assert property (@(posedge pclk)
        disable iff (!presetn)
        (st_r == s_stop && wake_stop) |=> !acs ##[1:OSC_MAX]
        (st_r == s_fetch)
        ) else $error("stop wake did not restart in time");

    // antecedent names the raw requests so a wrong wake_stop still fires
    a_adc_no_stop: assert property (@(posedge pclk)
        disable iff (!presetn)
        (st_r == s_stop && irq_adc && !irq_key && !irq_ext && !irq_nmi
        && !irq_usb_vbus && !irq_usb_resume && !irq_serial && !irq_timer)
        |=> st_r == s_stop
        ) else $error("adc interrupt ended stop mode");

    a_wait_wake: assert property (@(posedge pclk)
        disable iff (!presetn)
        (st_r == s_wait && wake_wait) |=> st_r == s_fetch && info_rd_r
        && $stable(ctl0_r)
        ) else $error("wait wake did not enter interrupt");

    a_entry_order: assert property (@(posedge pclk)
        disable iff (!presetn)
        info_rd_r |=> req_clr_r ##1 flg_save_r ##1 flg_clr_r
        ##1 push_flg_r ##1 push_pc_r ##1 (ipl_load_r
        && ipl_val_r == lvl_r)
        ) else $error("interrupt entry steps out of order");

    a_lp_main_off: assert property (@(posedge pclk)
        disable iff (!presetn)
        (syssel && mosc) [*2] |-> !main_osc_en_r && !periph_clk_en_r
        ) else $error("low power mode left main clock on");

endmodule // pmc_ctrl

// ---- core/pmc_pkg.sv ----
package pmc_pkg;

    // register byte offsets on the apb slave
    localparam logic [7:0] OFS_CLKCTL0 = 8'h00;
    localparam logic [7:0] OFS_CLKCTL1 = 8'h04;
    localparam logic [7:0] OFS_PROTECT = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0C;

    // clock control 0 fields
    localparam int B0_WPCS   = 2;
    localparam int B0_MOSC   = 5;
    localparam int B0_DIV0   = 6;
    localparam int B0_SYSSEL = 7;
    // clock control 1 fields
    localparam int B1_ACS    = 0;
    localparam int B1_DIVLO  = 6;
    localparam int B1_DIVHI  = 7;
    // protect register field
    localparam int BP_WEN    = 0;

    // reset values: main clock divided by eight
    localparam logic [7:0] CLKCTL0_RST = 8'h40;
    localparam logic [7:0] CLKCTL1_RST = 8'h00;

    // divider shift codes (ratio = 2 ** code)
    localparam logic [2:0] SH_DIV1  = 3'h0;
    localparam logic [2:0] SH_DIV2  = 3'h1;
    localparam logic [2:0] SH_DIV4  = 3'h2;
    localparam logic [2:0] SH_DIV8  = 3'h3;
    localparam logic [2:0] SH_DIV16 = 3'h4;

    // interrupt information fetch address
    localparam logic [19:0] INT_INFO_ADDR = 20'h0_0000;
    // software interrupt numbers that keep the stack select flag
    localparam logic [5:0] SWI_LO = 6'h20;
    localparam logic [5:0] SWI_HI = 6'h3F;

    // oscillator start-up wait after stop mode
    localparam int OSC_STAB_NS = 1000;
    localparam int CLK_MHZ     = 125;
    localparam int OSC_STAB_CYC = (OSC_STAB_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [3:0] {
        s_run,
        s_wait,
        s_stop,
        s_osc,
        s_fetch,
        s_clr,
        s_save,
        s_flags,
        s_pushf,
        s_pushpc,
        s_ipl
    } pmc_state_t;

endpackage

// ---- verif/pmc_ctrl_tb.sv ----
`timescale 1ns/1ps
module pmc_ctrl_tb;
    import pmc_pkg::*;

    localparam int OSC_N = 4;
    typedef struct packed {
        logic       wt;
        logic       wpcs;
        logic [8:0] irq;
        logic [4:0] qual;
        logic       wake;
    } pmc_row_t;
    typedef struct packed {
        logic [7:0] c0;
        logic [7:0] c1;
        logic [7:0] per;
    } pmc_div_t;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        wait_req;
    logic        sub_osc_in;
    logic [8:0]  irq;
    logic [4:0]  qual;
    logic [5:0]  int_info_num;
    logic [2:0]  int_info_lvl;
    logic        bclk_tick;
    wire  [3:0]  en_v;
    logic        subclk_periph_en_r;
    logic        info_rd_r;
    logic [19:0] info_addr;
    wire  [5:0]  seq_v;
    logic        u_keep_r;
    logic [2:0]  ipl_val_r;
    logic [31:0] q;
    logic        err;
    pmc_row_t    r;
    pmc_row_t    rows [21];
    pmc_div_t    divs [5];
    int          num_errors;
    int          n_tests;
    int          cyc;
    int          sub_cnt;

    pmc_ctrl #(.OSC_N(OSC_N)) pmc_ctrl_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wait_req(wait_req),
        .sub_osc_in(sub_osc_in), .irq_key(irq[8]), .irq_adc(irq[7]),
        .irq_serial(irq[6]), .irq_timer(irq[5]), .irq_usb_resume(irq[4]),
        .irq_usb_vbus(irq[3]), .irq_usb_other(irq[2]), .irq_ext(irq[1]),
        .irq_nmi(irq[0]), .adc_one_shot(qual[4]),
        .serial_ext_clk(qual[3]), .timer_event_cnt(qual[2]),
        .timer_src_subclock_div32(qual[1]), .usb_suspended(qual[0]),
        .int_info_num(int_info_num), .int_info_lvl(int_info_lvl),
        .bclk_tick(bclk_tick), .cpu_run_r(en_v[3]),
        .main_osc_en_r(en_v[2]), .sub_osc_en_r(en_v[1]),
        .periph_clk_en_r(en_v[0]),
        .subclk_periph_en_r(subclk_periph_en_r), .info_rd_r(info_rd_r),
        .info_addr(info_addr), .req_clr_r(seq_v[5]),
        .flg_save_r(seq_v[4]), .flg_clr_r(seq_v[3]), .u_keep_r(u_keep_r),
        .push_flg_r(seq_v[2]), .push_pc_r(seq_v[1]),
        .ipl_load_r(seq_v[0]), .ipl_val_r(ipl_val_r)
    );

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // free-running sub crystal, ten pclk per period
    always @(posedge pclk)
    begin
        sub_cnt <= (sub_cnt == 4) ? 0 : sub_cnt + 1;
        if (sub_cnt == 4)
            sub_osc_in <= ~sub_osc_in;
    end

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp_v);
        n_tests++;
        if (got !== exp_v)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp_v);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // only the global cycle ceiling ends a hung access
        while (pready !== 1'b1)
            @(posedge pclk);
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp_v);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp_v);
    endtask

    task automatic pulse_wait();
        wait_req <= 1'b1;
        @(posedge pclk);
        wait_req <= 1'b0;
        @(posedge pclk);
    endtask

    // period between the second and third bus clock enables
    task automatic meas(input int exp_p);
        int k;
        for (int t = 0; t < 3; t++)
        begin
            k = 0;
            @(negedge pclk);
            while (bclk_tick !== 1'b1 && k < 40)
            begin
                k++;
                @(negedge pclk);
            end
        end
        chk(32'(k + 1), 32'(exp_p));
        @(posedge pclk);
    endtask

    task automatic wake_seq(input int lat);
        int k;
        k = 0;
        @(negedge pclk);
        while (info_rd_r !== 1'b1 && k < 40)
        begin
            k++;
            @(negedge pclk);
        end
        chk(32'(k), 32'(lat));
        chk(32'(info_addr), 32'(INT_INFO_ADDR));
        for (int s = 0; s < 6; s++)
        begin
            @(negedge pclk);
            chk(32'(seq_v), 32'(6'h20 >> s));
            if (s == 2)
                chk(32'(u_keep_r), 32'(int_info_num >= SWI_LO));
        end
        @(negedge pclk);
        chk(32'({en_v[3], ipl_val_r}), 32'({1'b1, int_info_lvl}));
        @(posedge pclk);
        irq <= '0;
    endtask

    initial
    begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; wait_req = 1'b0; sub_osc_in = 1'b0;
        irq = '0; qual = '0; int_info_num = 6'h25; int_info_lvl = 3'h5;
        num_errors = 0; n_tests = 0; cyc = 0; sub_cnt = 0;
        divs = '{'{8'h40, 8'h00, 8'h08}, '{8'h00, 8'h00, 8'h01},
                 '{8'h00, 8'h40, 8'h02}, '{8'h00, 8'h80, 8'h04},
                 '{8'h00, 8'hC0, 8'h10}};
        rows = '{'{0, 0, 9'h080, 5'h10, 0}, '{0, 0, 9'h040, 5'h00, 0},
                 '{0, 0, 9'h040, 5'h08, 1}, '{0, 0, 9'h020, 5'h02, 0},
                 '{0, 0, 9'h020, 5'h04, 1}, '{0, 0, 9'h010, 5'h00, 0},
                 '{0, 0, 9'h010, 5'h01, 1}, '{0, 0, 9'h004, 5'h01, 0},
                 '{0, 0, 9'h008, 5'h00, 1}, '{0, 0, 9'h100, 5'h00, 1},
                 '{0, 0, 9'h002, 5'h00, 1}, '{0, 0, 9'h001, 5'h00, 1},
                 '{1, 0, 9'h080, 5'h10, 1}, '{1, 0, 9'h080, 5'h00, 0},
                 '{1, 0, 9'h040, 5'h00, 1}, '{1, 1, 9'h080, 5'h10, 0},
                 '{1, 1, 9'h040, 5'h00, 0}, '{1, 1, 9'h040, 5'h08, 1},
                 '{1, 1, 9'h020, 5'h02, 1}, '{1, 1, 9'h020, 5'h00, 0},
                 '{1, 1, 9'h004, 5'h00, 1}};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(OFS_CLKCTL0, 32'h0000_0040);
        rd_chk(OFS_CLKCTL1, 32'h0000_0000);
        rd_chk(OFS_STATUS, 32'h0000_001E);
        apb(1'b1, OFS_CLKCTL0, 32'h0000_0000);
        rd_chk(OFS_CLKCTL0, 32'h0000_0040);
        rd_chk(8'h10, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
        apb(1'b1, OFS_PROTECT, 32'h0000_0001);
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, OFS_CLKCTL0, 32'(divs[i].c0));
            apb(1'b1, OFS_CLKCTL1, 32'(divs[i].c1));
            meas(int'(divs[i].per));
        end
        for (int i = 0; i < 21; i++)
        begin
            r = rows[i];
            apb(1'b1, OFS_CLKCTL0, 32'({r.wpcs, 2'h0}));
            qual <= r.qual;
            if (r.wt)
                pulse_wait();
            else
                apb(1'b1, OFS_CLKCTL1, 32'h0000_0001);
            @(negedge pclk);
            chk(32'(en_v),
                32'({1'b0, r.wt, r.wt, r.wt & ~r.wpcs}));
            @(posedge pclk);
            irq <= r.irq;
            if (!r.wake)
            begin
                repeat (OSC_N + 4) @(negedge pclk);
                chk(32'(en_v[3]),
                    32'h0000_0000);
                @(posedge pclk);
                irq <= 9'h100;
            end
            wake_seq(r.wt ? 1 : OSC_N + 2);
        end
        qual <= '0;
        int_info_num <= 6'h05;
        int_info_lvl <= 3'h3;
        apb(1'b1, OFS_CLKCTL0, 32'h0000_0000);
        apb(1'b1, OFS_CLKCTL1, 32'h0000_0080);
        pulse_wait();
        irq <= 9'h100;
        wake_seq(1);
        meas(4);
        rd_chk(OFS_STATUS, 32'h0000_019E);
        apb(1'b1, OFS_CLKCTL1, 32'h0000_0041);
        irq <= 9'h002;
        wake_seq(OSC_N + 2);
        rd_chk(OFS_CLKCTL0, 32'h0000_0040);
        rd_chk(OFS_CLKCTL1, 32'h0000_0040);
        meas(8);
        apb(1'b1, OFS_CLKCTL0, 32'h0000_0080);
        meas(10);
        chk(32'(en_v[2]), 32'h0000_0001);
        apb(1'b1, OFS_CLKCTL1, 32'h0000_0001);
        irq <= 9'h001;
        wake_seq(OSC_N + 2);
        rd_chk(OFS_CLKCTL0, 32'h0000_0080);
        meas(10);
        apb(1'b1, OFS_CLKCTL0, 32'h0000_00A0);
        @(negedge pclk);
        chk(32'({en_v[2], en_v[0], subclk_periph_en_r}), 32'h1);
        meas(10);
        apb(1'b1, OFS_CLKCTL0, 32'h0000_0000);
        apb(1'b1, OFS_CLKCTL1, 32'h0000_0001);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(en_v[3]), 32'h0000_0001);
        rd_chk(OFS_CLKCTL0, 32'h0000_0040);
        rd_chk(OFS_CLKCTL1, 32'h0000_0000);
        report_and_stop();
    end

endmodule // pmc_ctrl_tb
